// *** cascade_cfg.svh ***
// offsets, field positions, reset values and timing counts for the light curtain block
// assumes a 10 MHz clock; included by the design and the bench
`ifndef CASCADE_CFG_SVH
`define CASCADE_CFG_SVH

`define IDX_EVAL_SEL 8'h48
`define IDX_TRIG 8'h49
`define SUB_WHOLE 8'h00
`define SEL_COUNT 16
`define SEL_W 8
`define SEL_FIRST_POS 120
`define PD_BITS 256
`define PD_BYTES 6'h20
`define BEAMS_PER_CASCADE 16
`define SEL_RESET 128'hca00_0000_0000_0000_0000_0000_0000_0000
`define TRIG_RESET 64'h0000_01f4_0064_0001
`define POS_CASCADE 56
`define POS_ROLE 48
`define POS_DELAY 32
`define POS_WIDTH 16
`define POS_CYCLE 0
`define CODE_NONE 8'h00
`define CODE_STREAM_MAX 8'h6f
`define CODE_FIRST_BLOCKED 8'hc8
`define CODE_FIRST_CLEAR 8'hc9
`define CODE_LAST_BLOCKED 8'hca
`define CODE_LAST_CLEAR 8'hcb
`define CODE_BLOCKED_COUNT 8'hcc
`define CODE_CLEAR_COUNT 8'hcd
`define CODE_AREAS_LO 8'hd0
`define CODE_AREAS_HI 8'hd1
`define CODE_OUTPUTS 8'hd2
`define CODE_STATUS 8'hd4
`define DELAY_MIN 16'h01f4
`define WIDTH_MIN 16'h0064
`define CYCLE_MIN 16'h0001
`define CYCLE_MAX 16'h1964
`define CLK_PERIOD_NS 100
`define US_NS 1000
`define US_PER_MS 1000
`define CYC_PER_US ((`US_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** cascade_pkg.sv ***
// types shared by the process data and cascade trigger logic
// assumes cascade_cfg.svh for all numeric constants
package cascade_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] index;
        logic [7:0] subindex;
        logic [127:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [127:0] rdata;
    } cfg_rsp_t;

    typedef struct packed {
        logic [15:0] first_blocked_beam;
        logic [15:0] first_clear_beam;
        logic [15:0] last_blocked_beam;
        logic [15:0] last_clear_beam;
        logic [15:0] blocked_beam_count;
        logic [15:0] clear_beam_count;
        logic [31:0] area_states;
        logic [15:0] output_states;
        logic [15:0] status_word;
    } eval_in_t;

    typedef struct packed {
        logic [7:0] cascade;
        logic [7:0] role;
        logic [15:0] delay_us;
        logic [15:0] width_us;
        logic [15:0] cycle_ms;
    } trig_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DELAY,
        ST_BUSY
    } meas_state_t;

endpackage : cascade_pkg

// *** process_data_and_cascade_trigger.sv ***
// process data assembler and cascade trigger unit for a measuring light curtain
// assumes all inputs synchronous to clock; evaluator supplies beams and results per scan
//
// How it works
// - process data capped at 32 bytes
// - beam stream packs one bit per beam
// - sixteen 8-bit selectors, first at bit 120
// - codes 1..111 emit 16-beam cascades each
// - code 0 contributes nothing
// - 200/201 first blocked / first clear beam
// - 202/203 last blocked / last clear beam
// - 204/205 blocked / clear beam counts
// - 208/209 area states low / high
// - 210 area-mapped output states
// - 212 device status word
// - selector one resets to 202, others 0
// - cascade 0 continuous, 1 trigger driven
// - role 0 slave, 1 master
// - master drives cyclic trigger
// - slave starts after programmed delay
`timescale 1ns/1ps
`include "cascade_cfg.svh"

module process_data_and_cascade_trigger #(
    parameter int NUM_BEAMS = `PD_BITS
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire cascade_pkg::cfg_req_t cfg_req,
    output cascade_pkg::cfg_rsp_t cfg_rsp,
    input wire logic [NUM_BEAMS-1:0] beam_state,
    input wire cascade_pkg::eval_in_t eval_in,
    input wire logic scan_done,
    output logic meas_start,
    output logic [`PD_BITS-1:0] process_data,
    output logic [5:0] process_data_len,
    output logic process_data_valid,
    output logic trigger_missed,
    input wire logic trigger_i,
    output logic trigger_o,
    output logic trigger_oe
);

    function automatic logic sel_legal(input logic [7:0] s);
        sel_legal = (s <= `CODE_STREAM_MAX) ||
                    (s >= `CODE_FIRST_BLOCKED && s <= `CODE_CLEAR_COUNT) ||
                    (s >= `CODE_AREAS_LO && s <= `CODE_OUTPUTS) ||
                    (s == `CODE_STATUS);
    endfunction : sel_legal

    function automatic logic [15:0] result_word(input logic [7:0] s,
                                                input cascade_pkg::eval_in_t ev);
        case (s)
            `CODE_FIRST_BLOCKED: result_word = ev.first_blocked_beam;
            `CODE_FIRST_CLEAR: result_word = ev.first_clear_beam;
            `CODE_LAST_BLOCKED: result_word = ev.last_blocked_beam;
            `CODE_LAST_CLEAR: result_word = ev.last_clear_beam;
            `CODE_BLOCKED_COUNT: result_word = ev.blocked_beam_count;
            `CODE_CLEAR_COUNT: result_word = ev.clear_beam_count;
            `CODE_AREAS_LO: result_word = ev.area_states[15:0];
            `CODE_AREAS_HI: result_word = ev.area_states[31:16];
            `CODE_OUTPUTS: result_word = ev.output_states;
            `CODE_STATUS: result_word = ev.status_word;
            default: result_word = 16'h0000;
        endcase
    endfunction : result_word

    // slots fill from the top bit down; anything past 32 bytes is cut
    function automatic logic [`PD_BITS+5:0] assemble(input logic [127:0] sel,
                                                     input logic [NUM_BEAMS-1:0] beams,
                                                     input cascade_pkg::eval_in_t ev);
        logic [`PD_BITS-1:0] pd;
        logic [7:0] s;
        logic [15:0] w;
        int pos;
        int bptr;
        int len;
        pd = '0;
        pos = 0;
        bptr = 0;
        for (int i = 0; i < `SEL_COUNT; i++) begin
            // selector i at offset 120 - 8*i
            s = sel[`SEL_FIRST_POS - `SEL_W * i +: `SEL_W];
            w = result_word(s, ev);
            if (s == `CODE_NONE) begin
                len = 0;
            end else if (s <= `CODE_STREAM_MAX) begin
                // one bit per beam, 16 beams per cascade
                len = int'(s) * `BEAMS_PER_CASCADE;
                for (int b = 0; b < `PD_BITS; b++) begin
                    if (b < len && pos + b < `PD_BITS && bptr + b < NUM_BEAMS) begin
                        pd[`PD_BITS - 1 - pos - b] = beams[bptr + b];
                    end
                end
                bptr = bptr + len;
            end else begin
                len = 16;
                for (int b = 0; b < 16; b++) begin
                    if (pos + b < `PD_BITS) begin
                        pd[`PD_BITS - 1 - pos - b] = w[15 - b];
                    end
                end
            end
            pos = pos + len;
        end
        if (pos >= `PD_BITS) begin
            assemble = {`PD_BYTES, pd};
        end else begin
            assemble = {6'((pos + 7) / 8), pd};
        end
    endfunction : assemble

    logic [127:0] sel_q;
    logic [63:0] trig_q;
    cascade_pkg::trig_cfg_t tcfg;
    cascade_pkg::cfg_rsp_t rsp_q;
    assign tcfg = cascade_pkg::trig_cfg_t'(trig_q);
    assign cfg_rsp = rsp_q;

    wire logic access = cfg_req.wr || cfg_req.rd;
    wire logic hit_sel = cfg_req.index == `IDX_EVAL_SEL;
    wire logic hit_trig = cfg_req.index == `IDX_TRIG;
    // only the whole record is reachable
    wire logic whole = cfg_req.subindex == `SUB_WHOLE;
    wire cascade_pkg::trig_cfg_t wt = cascade_pkg::trig_cfg_t'(cfg_req.wdata[63:0]);
    wire logic trig_ok = wt.cascade <= 8'h01 && wt.role <= 8'h01 &&
                         wt.delay_us >= `DELAY_MIN && wt.width_us >= `WIDTH_MIN &&
                         wt.cycle_ms >= `CYCLE_MIN && wt.cycle_ms <= `CYCLE_MAX;
    logic sel_ok;
    always_comb begin
        sel_ok = 1'b1;
        for (int i = 0; i < `SEL_COUNT; i++) begin
            if (!sel_legal(cfg_req.wdata[`SEL_W * i +: `SEL_W])) begin
                sel_ok = 1'b0;
            end
        end
    end
    wire logic data_ok = cfg_req.rd || (hit_sel ? sel_ok : trig_ok);
    wire logic req_ok = whole && (hit_sel || hit_trig) && data_ok;
    wire logic wr_sel = cfg_req.wr && req_ok && hit_sel;
    wire logic wr_trig = cfg_req.wr && req_ok && hit_trig;
    wire logic [127:0] rd_val = hit_sel ? sel_q : {64'h0, trig_q};

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            // selector one defaults to last blocked beam
            sel_q <= `SEL_RESET;
            trig_q <= `TRIG_RESET;
            rsp_q <= '0;
        end else begin
            if (wr_sel) begin
                sel_q <= cfg_req.wdata;
            end
            if (wr_trig) begin
                trig_q <= cfg_req.wdata[63:0];
            end
            rsp_q.ack <= access;
            rsp_q.err <= access && !req_ok;
            rsp_q.rdata <= (cfg_req.rd && req_ok) ? rd_val : 128'h0;
        end
    end

    // timebase: one enable pulse per microsecond
    logic [3:0] div_q;
    wire logic tick_us = div_q == 4'(`CYC_PER_US - 1);
    logic [22:0] period_q;
    logic [15:0] delay_q;
    logic trig_prev_q;
    logic start_q;
    logic missed_q;
    cascade_pkg::meas_state_t state_q;

    wire logic is_master = tcfg.cascade[0] && tcfg.role[0];
    wire logic is_slave = tcfg.cascade[0] && !tcfg.role[0];
    wire logic [22:0] period_len = 23'(tcfg.cycle_ms * `US_PER_MS);
    wire logic period_wrap = period_q >= period_len - 23'h1;
    wire logic master_fire = is_master && tick_us && period_q == 23'h0;
    wire logic slave_edge = is_slave && trigger_i && !trig_prev_q;
    wire logic delay_done = state_q == cascade_pkg::ST_DELAY && tick_us && delay_q <= 16'h1;
    wire logic cont_go = !tcfg.cascade[0] && state_q == cascade_pkg::ST_IDLE && !start_q;
    wire logic go = cont_go || delay_done ||
                    (master_fire && state_q == cascade_pkg::ST_IDLE);
    // a trigger that lands on a running scan is dropped, not queued
    wire logic drop = (master_fire || slave_edge) && state_q != cascade_pkg::ST_IDLE;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 4'h0;
            period_q <= 23'h0;
            trig_prev_q <= 1'b0;
        end else begin
            div_q <= tick_us ? 4'h0 : div_q + 4'h1;
            trig_prev_q <= trigger_i;
            if (!is_master) begin
                period_q <= 23'h0;
            end else if (tick_us) begin
                period_q <= period_wrap ? 23'h0 : period_q + 23'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= cascade_pkg::ST_IDLE;
            delay_q <= 16'h0;
            start_q <= 1'b0;
            missed_q <= 1'b0;
        end else begin
            start_q <= go;
            missed_q <= drop;
            case (state_q)
                cascade_pkg::ST_IDLE: begin
                    if (slave_edge) begin
                        delay_q <= tcfg.delay_us;
                        state_q <= cascade_pkg::ST_DELAY;
                    end else if (go) begin
                        state_q <= cascade_pkg::ST_BUSY;
                    end
                end
                cascade_pkg::ST_DELAY: begin
                    if (!is_slave) begin
                        state_q <= cascade_pkg::ST_IDLE;
                    end else if (delay_done) begin
                        state_q <= cascade_pkg::ST_BUSY;
                    end else if (tick_us) begin
                        delay_q <= delay_q - 16'h1;
                    end
                end
                cascade_pkg::ST_BUSY: begin
                    if (scan_done) begin
                        state_q <= cascade_pkg::ST_IDLE;
                    end
                end
                default: state_q <= cascade_pkg::ST_IDLE;
            endcase
        end
    end

    // pulse high for width from period start
    logic trig_o_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            trig_o_q <= 1'b0;
        end else begin
            trig_o_q <= is_master && (period_q < 23'(tcfg.width_us));
        end
    end

    assign meas_start = start_q;
    assign trigger_missed = missed_q;
    assign trigger_o = trig_o_q;
    assign trigger_oe = is_master;

    // process data refreshed once per finished scan
    logic [`PD_BITS-1:0] pd_q;
    logic [5:0] len_q;
    logic pd_valid_q;
    wire logic [`PD_BITS+5:0] pd_next = assemble(sel_q, beam_state, eval_in);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pd_q <= '0;
            len_q <= 6'h0;
            pd_valid_q <= 1'b0;
        end else begin
            pd_valid_q <= scan_done;
            if (scan_done) begin
                pd_q <= pd_next[`PD_BITS-1:0];
                len_q <= pd_next[`PD_BITS+5:`PD_BITS];
            end
        end
    end
    assign process_data = pd_q;
    assign process_data_len = len_q;
    assign process_data_valid = pd_valid_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_slave_armed;
        slave_edge && state_q == cascade_pkg::ST_IDLE;
    endsequence
    sequence s_in_delay;
        state_q == cascade_pkg::ST_DELAY;
    endsequence

    a_len_capped: assert property (process_data_len <= `PD_BYTES)
        else $error("process data length above 32 bytes");
    a_sub_refused: assert property (access && !whole |=> cfg_rsp.ack && cfg_rsp.err)
        else $error("partial record access not refused");
    a_sel_kept: assert property (cfg_req.wr && !whole |=> $stable(sel_q) && $stable(trig_q))
        else $error("partial write changed a record");
    a_sel_written: assert property (wr_sel |=> sel_q == $past(cfg_req.wdata))
        else $error("selector record not stored");
    a_pd_refresh: assert property (scan_done |=> process_data_valid)
        else $error("process data not refreshed after scan");
    a_cont_start: assert property (cont_go |=> meas_start ##1 !meas_start)
        else $error("continuous scan did not start");
    a_slave_delay: assert property (s_slave_armed |=> s_in_delay ##1 !meas_start)
        else $error("slave started without delay");
    a_master_fire: assert property (master_fire && state_q == cascade_pkg::ST_IDLE
        |=> meas_start && state_q == cascade_pkg::ST_BUSY)
        else $error("master trigger did not start scan");
    a_pulse_hold: assert property ($rose(trigger_o) |-> trigger_o [*8])
        else $error("trigger pulse too short");
    a_us_tick: assert property (tick_us |=> !tick_us [*8] ##1 !tick_us ##1 tick_us)
        else $error("microsecond tick spacing wrong");
    a_oe_role: assert property (trigger_o |-> trigger_oe)
        else $error("trigger driven while not master");

endmodule : process_data_and_cascade_trigger

// *** process_data_and_cascade_trigger_test.sv ***
// bench for process data assembly and cascade trigger timing
// assumes scan_partner as evaluator; bench plays the other curtains
`timescale 1ns/1ps
`include "cascade_cfg.svh"
module process_data_and_cascade_trigger_test;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    cascade_pkg::cfg_req_t cfg_req = '0;
    cascade_pkg::cfg_rsp_t cfg_rsp;
    logic [255:0] beam_state = '0;
    cascade_pkg::eval_in_t eval_in = '0;
    logic scan_done, meas_start, process_data_valid, trigger_missed;
    logic trigger_o, trigger_oe;
    logic allow = 1'b0;
    logic trigger_i = 1'b0;
    logic [255:0] process_data;
    logic [5:0] process_data_len;
    logic [263:0] rsp_q[$];
    logic [263:0] pd_q[$];
    int fails = 0;
    int n_tests = 0;
    int n_seen = 0;
    always #50 clock = ~clock;
    process_data_and_cascade_trigger process_data_and_cascade_trigger_inst (
        .clock(clock), .reset_n(reset_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
        .beam_state(beam_state), .eval_in(eval_in), .scan_done(scan_done),
        .meas_start(meas_start), .process_data(process_data),
        .process_data_len(process_data_len), .process_data_valid(process_data_valid),
        .trigger_missed(trigger_missed), .trigger_i(trigger_i),
        .trigger_o(trigger_o), .trigger_oe(trigger_oe));
    scan_partner scan_partner_inst (.clock(clock), .reset_n(reset_n),
        .meas_start(meas_start), .allow(allow), .scan_done(scan_done));
    task automatic give_verdict();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [263:0] got, input logic [263:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // monitor: oldest note against each answer
    always @(negedge clock) begin
        if (cfg_rsp.ack === 1'b1) begin
            if (rsp_q.size() == 0) check(264'h1, 264'h0);
            else check({cfg_rsp.err, cfg_rsp.rdata}, rsp_q.pop_front());
        end
        if (process_data_valid === 1'b1) begin
            n_seen++;
            if (pd_q.size() == 0) check(264'h1, 264'h0);
            else check({process_data_len, process_data}, pd_q.pop_front());
        end
    end
    task automatic cfg(input logic w, input logic [7:0] ix, input logic [7:0] sb,
                       input logic [127:0] d, input logic e, input logic [127:0] r);
        rsp_q.push_back({e, r});
        @(negedge clock);
        cfg_req = '{wr: w, rd: !w, index: ix, subindex: sb, wdata: d};
        @(negedge clock);
        cfg_req = '0;
        @(negedge clock);
        // no ack seen means the note is still queued
        if (rsp_q.size() != 0) begin
            check(264'h1, 264'h0);
            rsp_q.delete();
        end
    endtask : cfg
    function automatic logic [263:0] exp_pd(input logic [127:0] s);
        logic [255:0] pd;
        logic [7:0] c;
        logic [15:0] w;
        int pos;
        int bi;
        pd = '0;
        pos = 0;
        bi = 0;
        for (int i = 0; i < 16; i++) begin
            c = s[120-8*i +: 8];
            if (c >= 8'h01 && c <= `CODE_STREAM_MAX) begin
                // beams continue across stream slots
                for (int j = 0; j < c * 16; j++) begin
                    if (pos < 256 && bi < 256) pd[255-pos] = beam_state[bi];
                    pos++;
                    bi++;
                end
            end else if (c != `CODE_NONE) begin
                case (c)
                    `CODE_FIRST_BLOCKED: w = eval_in.first_blocked_beam;
                    `CODE_FIRST_CLEAR: w = eval_in.first_clear_beam;
                    `CODE_LAST_BLOCKED: w = eval_in.last_blocked_beam;
                    `CODE_LAST_CLEAR: w = eval_in.last_clear_beam;
                    `CODE_BLOCKED_COUNT: w = eval_in.blocked_beam_count;
                    `CODE_CLEAR_COUNT: w = eval_in.clear_beam_count;
                    `CODE_AREAS_LO: w = eval_in.area_states[15:0];
                    `CODE_AREAS_HI: w = eval_in.area_states[31:16];
                    `CODE_OUTPUTS: w = eval_in.output_states;
                    default: w = eval_in.status_word;
                endcase
                for (int j = 0; j < 16; j++) begin
                    if (pos < 256) pd[255-pos] = w[15-j];
                    pos++;
                end
            end
        end
        return {2'b00, (pos >= 256) ? `PD_BYTES : 6'((pos + 7) / 8), pd};
    endfunction : exp_pd
    task automatic do_scan(input logic [127:0] s);
        int k;
        for (k = 0; k < 8; k++) beam_state[32*k +: 32] = $urandom;
        for (k = 0; k < 5; k++) eval_in[32*k +: 32] = $urandom;
        pd_q.push_back(exp_pd(s));
        k = n_seen;
        allow = 1'b1;
        for (int t = 0; t < 60 && n_seen == k; t++) @(negedge clock);
        allow = 1'b0;
        if (n_seen == k) begin
            fails++;
            give_verdict();
        end
    endtask : do_scan
    task automatic wait_for(input logic m, input logic v, output int n);
        n = 0;
        while ((m ? meas_start : trigger_o) !== v && n < 30000) begin
            @(negedge clock);
            n++;
        end
        if (n >= 30000) begin
            fails++;
            give_verdict();
        end
    endtask : wait_for
    initial begin
        logic [127:0] sets[4];
        int n;
        int h;
        int l;
        sets = '{128'h01c8_c9ca_cbcc_cdd0_d1d2_d400_0000_0000,
                 128'h0002_0003_cc00_0000_0000_0000_0000_0005,
                 128'h10c8_0100_0000_0000_0000_0000_0000_0000, 128'h0};
        void'($urandom(32'hc95a));
        repeat (4) @(negedge clock);
        reset_n = 1'b1;
        cfg(0, `IDX_EVAL_SEL, 8'h00, '0, 0, `SEL_RESET);
        cfg(0, `IDX_TRIG, 8'h00, '0, 0, {64'h0, `TRIG_RESET});
        cfg(1, `IDX_EVAL_SEL, 8'h01, '1, 1, '0);
        cfg(0, `IDX_TRIG, 8'h02, '0, 1, '0);
        cfg(1, 8'h4a, 8'h00, '0, 1, '0);
        cfg(1, `IDX_EVAL_SEL, 8'h00, {8'h70, 120'h0}, 1, '0);
        cfg(1, `IDX_EVAL_SEL, 8'h00, {8'h00, 8'hce, 112'h0}, 1, '0);
        cfg(1, `IDX_TRIG, 8'h00, 128'h0000_01f3_0064_0001, 1, '0);
        cfg(1, `IDX_TRIG, 8'h00, 128'h0000_01f4_0063_0001, 1, '0);
        cfg(1, `IDX_TRIG, 8'h00, 128'h0000_01f4_0064_1965, 1, '0);
        cfg(1, `IDX_TRIG, 8'h00, 128'h0200_01f4_0064_0001, 1, '0);
        cfg(1, `IDX_TRIG, 8'h00, 128'h0002_01f4_0064_0001, 1, '0);
        cfg(0, `IDX_EVAL_SEL, 8'h00, '0, 0, `SEL_RESET);
        for (int i = 0; i < 4; i++) begin
            cfg(1, `IDX_EVAL_SEL, 8'h00, sets[i], 0, '0);
            cfg(0, `IDX_EVAL_SEL, 8'h00, '0, 0, sets[i]);
            do_scan(sets[i]);
        end
        cfg(1, `IDX_EVAL_SEL, 8'h00, sets[0], 0, '0);
        for (int d = 500; d <= 700; d += 200) begin
            // distinct delays per slave
            cfg(1, `IDX_TRIG, 8'h00, {64'h0, 16'h0100, 16'(d), 32'h0064_0001}, 0, '0);
            do_scan(sets[0]);
            check(trigger_oe, 1'b0);
            h = 0;
            repeat (200) @(negedge clock) if (meas_start === 1'b1) h++;
            check(h, 0);
            trigger_i = 1'b1;
            wait_for(1, 1, n);
            check(n >= d * `CYC_PER_US - 15 && n <= d * `CYC_PER_US + 25, 1);
            trigger_i = 1'b0;
            repeat (3) @(negedge clock);
            trigger_i = 1'b1;
            h = 0;
            repeat (5) @(negedge clock) if (trigger_missed === 1'b1) h++;
            check(h, 1);
            trigger_i = 1'b0;
        end
        cfg(1, `IDX_TRIG, 8'h00, 128'h0101_01f4_0064_0001, 0, '0);
        do_scan(sets[0]);
        check(trigger_oe, 1'b1);
        wait_for(1, 1, n);
        check(n <= `US_PER_MS * `CYC_PER_US + 20, 1);
        // sync to the end of a pulse, then time one low and one high phase
        wait_for(0, 0, n);
        wait_for(0, 1, l);
        wait_for(0, 0, h);
        check(h >= 980 && h <= 1020, 1);
        check(h + l >= 9980 && h + l <= 10020, 1);
        give_verdict();
    end
endmodule : process_data_and_cascade_trigger_test

// *** scan_partner.sv ***
// evaluator stand-in: answers each meas_start with one scan_done
// assumes the bench raises allow for every scan it wants finished
`timescale 1ns/1ps
module scan_partner (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic meas_start,
    input wire logic allow,
    output logic scan_done
);
    logic pend_q;
    logic [3:0] cnt_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pend_q <= 1'b0;
            cnt_q <= 4'h0;
            scan_done <= 1'b0;
        end else begin
            scan_done <= 1'b0;
            if (meas_start) begin
                pend_q <= 1'b1;
                cnt_q <= 4'h0;
            end else if (pend_q && cnt_q < 4'h3) begin
                cnt_q <= cnt_q + 4'h1;
            end else if (pend_q && allow) begin
                // held scans keep the block busy, so triggers get dropped
                pend_q <= 1'b0;
                scan_done <= 1'b1;
            end
        end
    end
endmodule : scan_partner
